//--- core/ec_ctrl_pkg.sv
package ec_ctrl_pkg;
  // Register indices on the plain byte port
  localparam logic [3:0] ADDR_LINE_SET = 4'h4;
  localparam logic [3:0] ADDR_ACOUSTIC_SET = 4'h5;
  localparam logic [3:0] ADDR_MEM_ADDR_HI = 4'h6;
  localparam logic [3:0] ADDR_MEM_ADDR_LO = 4'h7;
  localparam logic [3:0] ADDR_MEM_DATA_HI = 4'h8;
  localparam logic [3:0] ADDR_MEM_DATA_LO = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'hB;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int BIT_BYPASS = 7;
  localparam int BIT_RESERVED = 6;
  localparam int BIT_COEF_FREEZE = 5;
  localparam int BIT_HOWL_OFF = 4;
  localparam int BIT_CENTER_CLIP = 3;
  localparam int BIT_NC_GAIN = 2;
  localparam int BIT_ATTEN = 1;
  localparam int BIT_GAINCTL_OFF = 0;
  localparam int BIT_WRITE_READY = 7;
  // Line register bits held here; others read as zero
  localparam logic [7:0] LINE_MASK = 8'h87;
  localparam logic [7:0] ACOUSTIC_MASK = 8'hBF;
  // Gains in dB per noise-canceler code step
  localparam logic [4:0] NC_STEP_DB = 5'h06;
  // Hold time, clock rate in MHz and hold time in clock cycles
  localparam int HOLD_US = 250;
  localparam int CLK_MHZ = 125;
  localparam int HOLD_CYCLES = HOLD_US * CLK_MHZ;
endpackage : ec_ctrl_pkg

//--- core/sync_sampler.sv
`timescale 1ns/1ps
module sync_sampler #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic capture_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] q;
  } state_s;
  state_s st_ff;
  state_s nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (capture_in) begin
      nxt_st.q = d_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_out = st_ff.q;
endmodule : sync_sampler

//--- core/echo_canceler_control_regs.sv
`timescale 1ns/1ps
module echo_canceler_control_regs (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic frame_sync_in,
  input wire logic initial_mode_in,
  input wire logic line_bypass_pin_in,
  input wire logic acoustic_bypass_pin_in,
  input wire logic nc_gain_sel_low_pin_in,
  input wire logic nc_gain_sel_high_pin_in,
  input wire logic line_atten_off_pin_in,
  input wire logic line_gainctl_off_pin_in,
  input wire logic acoustic_howl_off_pin_in,
  input wire logic acoustic_atten_pin_in,
  input wire logic acoustic_gainctl_off_pin_in,
  output logic [4:0] nc_post_gain_out,
  output logic [4:0] nc_input_loss_out,
  output logic line_bypass_out,
  output logic line_atten_en_out,
  output logic line_gain_ctl_en_out,
  output logic acoustic_bypass_out,
  output logic acoustic_coef_freeze_out,
  output logic acoustic_howl_en_out,
  output logic acoustic_center_clip_out,
  output logic acoustic_atten_en_out,
  output logic acoustic_atten_12db_out,
  output logic acoustic_gain_ctl_en_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_data_out,
  output logic mem_write_ready_out
);
  typedef struct packed {
    logic [7:0] line_set;
    logic [7:0] acoustic_set;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
    logic [7:0] rdata;
    logic sync_prev;
  } state_s;
  state_s st_ff;
  state_s nxt_st;
  logic sync_rise;
  logic [7:0] line_eff;
  logic [7:0] acoustic_eff;
  logic [7:0] line_smp;
  logic [7:0] acoustic_smp;
  logic [1:0] nc_code;
  logic [6:0] nc_db;
  logic line_normal;
  logic acoustic_normal;

  assign sync_rise = frame_sync_in & ~st_ff.sync_prev;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync_prev = frame_sync_in;
    nxt_st.rdata = 8'h00;
    if (wr_in) begin
      case (addr_in)
        ec_ctrl_pkg::ADDR_LINE_SET: nxt_st.line_set = wdata_in & ec_ctrl_pkg::LINE_MASK;
        // Reserved bit kept at zero whatever the host writes
        ec_ctrl_pkg::ADDR_ACOUSTIC_SET: nxt_st.acoustic_set = wdata_in & ec_ctrl_pkg::ACOUSTIC_MASK;
        ec_ctrl_pkg::ADDR_MEM_ADDR_HI: nxt_st.addr_hi = wdata_in;
        ec_ctrl_pkg::ADDR_MEM_ADDR_LO: nxt_st.addr_lo = wdata_in;
        ec_ctrl_pkg::ADDR_MEM_DATA_HI: nxt_st.data_hi = wdata_in;
        ec_ctrl_pkg::ADDR_MEM_DATA_LO: nxt_st.data_lo = wdata_in;
        default: begin
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        ec_ctrl_pkg::ADDR_LINE_SET: nxt_st.rdata = st_ff.line_set;
        ec_ctrl_pkg::ADDR_ACOUSTIC_SET: nxt_st.rdata = st_ff.acoustic_set;
        ec_ctrl_pkg::ADDR_MEM_ADDR_HI: nxt_st.rdata = st_ff.addr_hi;
        ec_ctrl_pkg::ADDR_MEM_ADDR_LO: nxt_st.rdata = st_ff.addr_lo;
        ec_ctrl_pkg::ADDR_MEM_DATA_HI: nxt_st.rdata = st_ff.data_hi;
        ec_ctrl_pkg::ADDR_MEM_DATA_LO: nxt_st.rdata = st_ff.data_lo;
        ec_ctrl_pkg::ADDR_STATUS: nxt_st.rdata[ec_ctrl_pkg::BIT_WRITE_READY] = initial_mode_in;
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pins ORed ahead of sampling so pin and bit see the same frame edge
  always_comb begin
    line_eff = st_ff.line_set;
    line_eff[ec_ctrl_pkg::BIT_BYPASS] = st_ff.line_set[ec_ctrl_pkg::BIT_BYPASS] | line_bypass_pin_in;
    line_eff[ec_ctrl_pkg::BIT_NC_GAIN] = st_ff.line_set[ec_ctrl_pkg::BIT_NC_GAIN] | nc_gain_sel_low_pin_in;
    line_eff[ec_ctrl_pkg::BIT_ATTEN] = st_ff.line_set[ec_ctrl_pkg::BIT_ATTEN] | line_atten_off_pin_in;
    line_eff[ec_ctrl_pkg::BIT_GAINCTL_OFF] =
      st_ff.line_set[ec_ctrl_pkg::BIT_GAINCTL_OFF] | line_gainctl_off_pin_in;
    acoustic_eff = st_ff.acoustic_set;
    acoustic_eff[ec_ctrl_pkg::BIT_BYPASS] =
      st_ff.acoustic_set[ec_ctrl_pkg::BIT_BYPASS] | acoustic_bypass_pin_in;
    acoustic_eff[ec_ctrl_pkg::BIT_HOWL_OFF] =
      st_ff.acoustic_set[ec_ctrl_pkg::BIT_HOWL_OFF] | acoustic_howl_off_pin_in;
    acoustic_eff[ec_ctrl_pkg::BIT_NC_GAIN] =
      st_ff.acoustic_set[ec_ctrl_pkg::BIT_NC_GAIN] | nc_gain_sel_high_pin_in;
    acoustic_eff[ec_ctrl_pkg::BIT_ATTEN] = st_ff.acoustic_set[ec_ctrl_pkg::BIT_ATTEN] | acoustic_atten_pin_in;
    acoustic_eff[ec_ctrl_pkg::BIT_GAINCTL_OFF] =
      st_ff.acoustic_set[ec_ctrl_pkg::BIT_GAINCTL_OFF] | acoustic_gainctl_off_pin_in;
  end

  sync_sampler #(
    .WIDTH(8)
  ) u_line_smp (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .capture_in(sync_rise),
    .d_in(line_eff),
    .q_out(line_smp)
  );

  sync_sampler #(
    .WIDTH(8)
  ) u_acoustic_smp (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .capture_in(sync_rise),
    .d_in(acoustic_eff),
    .q_out(acoustic_smp)
  );

  always_comb begin
    nc_code = {acoustic_smp[ec_ctrl_pkg::BIT_NC_GAIN], line_smp[ec_ctrl_pkg::BIT_NC_GAIN]};
    nc_db = 7'(nc_code) * 7'(ec_ctrl_pkg::NC_STEP_DB);
    line_normal = ~line_smp[ec_ctrl_pkg::BIT_BYPASS];
    acoustic_normal = ~acoustic_smp[ec_ctrl_pkg::BIT_BYPASS];
  end

  // Loss is reported as a positive dB magnitude of attenuation
  assign nc_post_gain_out = nc_db[4:0];
  assign nc_input_loss_out = nc_db[4:0];
  assign line_bypass_out = line_smp[ec_ctrl_pkg::BIT_BYPASS];
  assign line_atten_en_out = line_normal & ~line_smp[ec_ctrl_pkg::BIT_ATTEN];
  assign line_gain_ctl_en_out = line_normal & ~line_smp[ec_ctrl_pkg::BIT_GAINCTL_OFF];
  assign acoustic_bypass_out = acoustic_smp[ec_ctrl_pkg::BIT_BYPASS];
  assign acoustic_coef_freeze_out = acoustic_normal & acoustic_smp[ec_ctrl_pkg::BIT_COEF_FREEZE];
  assign acoustic_howl_en_out = acoustic_normal & ~acoustic_smp[ec_ctrl_pkg::BIT_HOWL_OFF];
  assign acoustic_center_clip_out = acoustic_normal & acoustic_smp[ec_ctrl_pkg::BIT_CENTER_CLIP];
  assign acoustic_atten_en_out = acoustic_normal;
  assign acoustic_atten_12db_out = acoustic_smp[ec_ctrl_pkg::BIT_ATTEN];
  assign acoustic_gain_ctl_en_out = acoustic_normal & ~acoustic_smp[ec_ctrl_pkg::BIT_GAINCTL_OFF];
  // Memory bytes go straight out; the commit sequence lives elsewhere
  assign mem_addr_out = {st_ff.addr_hi, st_ff.addr_lo};
  assign mem_data_out = {st_ff.data_hi, st_ff.data_lo};
  assign mem_write_ready_out = initial_mode_in;
  assign rdata_out = st_ff.rdata;
endmodule : echo_canceler_control_regs

//--- tb/ec_regs_monitor.sv
`timescale 1ns/1ps
module ec_regs_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic frame_sync_in,
  input wire logic initial_mode_in,
  input wire logic acoustic_howl_off_pin_in,
  input wire logic [4:0] nc_post_gain_out,
  input wire logic [4:0] nc_input_loss_out,
  input wire logic line_bypass_out,
  input wire logic line_atten_en_out,
  input wire logic line_gain_ctl_en_out,
  input wire logic acoustic_bypass_out,
  input wire logic acoustic_howl_en_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] mem_data_out,
  input wire logic mem_write_ready_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  property p_pair; nc_input_loss_out == nc_post_gain_out && nc_post_gain_out inside {0, 6, 12, 18}; endproperty
  a_pair: assert property (p_pair) else $error("gain and loss differ");
  property p_ready; mem_write_ready_out == initial_mode_in; endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");
  property p_lthru; line_bypass_out |-> !line_atten_en_out && !line_gain_ctl_en_out; endproperty
  a_lthru: assert property (p_lthru) else $error("line function in bypass");
  property p_athru; acoustic_bypass_out |-> !acoustic_howl_en_out; endproperty
  a_athru: assert property (p_athru) else $error("howl on in bypass");
  // Settings may only move in the cycle after a sync rise was seen
  property p_hold;
    !($past(frame_sync_in) && !$past(frame_sync_in, 2)) |-> $stable(nc_post_gain_out) && $stable(line_bypass_out);
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved off sync");
  property p_ahold; !($past(wr_in) && $past(addr_in) inside {4'h6, 4'h7}) |-> $stable(mem_addr_out); endproperty
  a_ahold: assert property (p_ahold) else $error("address moved");
  property p_dwr; $past(wr_in) && $past(addr_in) == 4'h9 |-> mem_data_out[7:0] == $past(wdata_in); endproperty
  a_dwr: assert property (p_dwr) else $error("data low not written");
  property p_howl; frame_sync_in && !$past(frame_sync_in) && acoustic_howl_off_pin_in |=> !acoustic_howl_en_out; endproperty
  a_howl: assert property (p_howl) else $error("howl pin ignored");
  cover property (line_bypass_out && acoustic_bypass_out);
  cover property (nc_post_gain_out == 5'h12);
  cover property (wr_in && addr_in == 4'h9);
endmodule : ec_regs_monitor
bind echo_canceler_control_regs ec_regs_monitor u_mon (.*);

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial {addr_out, wdata_out, wr_out, rd_out} = '0;
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= (a == 4'h5) ? d & 8'hBF : d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
  endtask : acc
endmodule : host_model

//--- tb/echo_canceler_control_regs_tb.sv
`timescale 1ns/1ps
module echo_canceler_control_regs_tb;
  logic ref_clk_in = 0, rst_in = 1, frame_sync_in = 0, initial_mode_in = 0, rd_d = 0, sy_d = 0, fs_d = 0;
  logic [8:0] pins = '0, p;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, lr, ar;
  logic wr, rd;
  logic [19:0] sv;
  logic [15:0] ma, md;
  logic mr;
  logic [7:0] mb[4];
  logic [31:0] rq[$], sq[$];
  int error_cnt = 0, checks = 0;
  host_model host (.ref_clk_in, .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  echo_canceler_control_regs DUT (.ref_clk_in, .rst_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .frame_sync_in, .initial_mode_in, .line_bypass_pin_in(pins[0]),
    .acoustic_bypass_pin_in(pins[1]), .nc_gain_sel_low_pin_in(pins[2]), .nc_gain_sel_high_pin_in(pins[3]),
    .line_atten_off_pin_in(pins[4]), .line_gainctl_off_pin_in(pins[5]), .acoustic_howl_off_pin_in(pins[6]),
    .acoustic_atten_pin_in(pins[7]), .acoustic_gainctl_off_pin_in(pins[8]), .nc_post_gain_out(sv[19:15]),
    .nc_input_loss_out(sv[14:10]), .line_bypass_out(sv[9]), .line_atten_en_out(sv[8]),
    .line_gain_ctl_en_out(sv[7]), .acoustic_bypass_out(sv[6]), .acoustic_coef_freeze_out(sv[5]),
    .acoustic_howl_en_out(sv[4]), .acoustic_center_clip_out(sv[3]), .acoustic_atten_en_out(sv[2]),
    .acoustic_atten_12db_out(sv[1]), .acoustic_gain_ctl_en_out(sv[0]), .mem_addr_out(ma), .mem_data_out(md),
    .mem_write_ready_out(mr));
  initial forever #4 ref_clk_in = ~ref_clk_in;
  function automatic logic [19:0] exp_set(logic [7:0] l, logic [7:0] a, logic [8:0] q);
    logic lb, ab;
    logic [4:0] g;
    lb = l[7] | q[0];
    ab = a[7] | q[1];
    g = 5'h06 * {3'h0, a[2] | q[3], l[2] | q[2]};
    return {g, g, lb, !(lb | l[1] | q[4]), !(lb | l[0] | q[5]), ab, !ab & a[5], !(ab | a[4] | q[6]), !ab & a[3],
      !ab, !ab & (a[1] | q[7]), !(ab | a[0] | q[8])};
  endfunction : exp_set
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    checks++;
    if (a !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask : rd_chk
  always @(posedge ref_clk_in) begin
    if (rd_d) check(rq.pop_front(), rdata);
    if (sy_d) check(sq.pop_front(), sv);
    rd_d <= rd;
    sy_d <= frame_sync_in & !fs_d;
    fs_d <= frame_sync_in;
  end
  initial begin
    void'($urandom(32'h9cf9));
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      lr = $urandom;
      mb[i] = lr;
      host.acc(1'b1, 4'h6 + 4'(i), lr);
      rd_chk(4'h6 + 4'(i), lr);
    end
    check({mb[0], mb[1], mb[2], mb[3]}, {ma, md});
    rd_chk(4'hA, 8'h00);
    check(32'h0000_0000, {31'h0, mr});
    initial_mode_in <= 1'b1;
    rd_chk(ec_ctrl_pkg::ADDR_STATUS, 8'h80);
    check(32'h0000_0001, {31'h0, mr});
    for (int i = 0; i < 12; i++) begin
      lr = (i < 4) ? {5'h00, i[0], 2'h0} : 8'($urandom);
      ar = (i < 4) ? {5'h00, i[1], 2'h0} : 8'($urandom);
      p = (i < 4) ? 9'h000 : 9'($urandom);
      // The 12 dB select is not defined in bypass, so keep it low there
      {ar[1], p[7]} = (ar[7] | p[1]) ? 2'b00 : {ar[1], p[7]};
      host.acc(1'b1, 4'h4, lr);
      host.acc(1'b1, 4'h5, ar);
      pins <= p;
      rd_chk(4'h4, lr & ec_ctrl_pkg::LINE_MASK);
      rd_chk(4'h5, ar & ec_ctrl_pkg::ACOUSTIC_MASK);
      sq.push_back(exp_set(lr, ar, p));
      @(posedge ref_clk_in);
      frame_sync_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      frame_sync_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
    end
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    error_cnt++;
    print_verdict();
  end
endmodule : echo_canceler_control_regs_tb
